// file: bgen_dpll_pkg.sv
// constants for the baud generator, line encoder and clock recovery block
package bgen_dpll_pkg;

   // register byte addresses on the wishbone slave
   localparam logic [7:0] ADDR_TC_LOW       = 8'h00;
   localparam logic [7:0] ADDR_TC_HIGH      = 8'h04;
   localparam logic [7:0] ADDR_BAUD_PLL_CTL = 8'h08;
   localparam logic [7:0] ADDR_MISC_LINE    = 8'h0c;
   localparam logic [7:0] ADDR_CLOCK_ROUTE  = 8'h10;
   localparam logic [7:0] ADDR_STATUS       = 8'h14;

   // baud_pll_control_reg fields
   localparam int BPC_ENABLE_BIT = 0;
   localparam int BPC_SOURCE_BIT = 1;
   localparam int BPC_CMD_LSB    = 5;
   localparam int BPC_CMD_MSB    = 7;

   // misc_line_control_reg encoding field
   localparam int MLC_ENC_LSB = 5;
   localparam int MLC_ENC_MSB = 6;

   // status register bit positions
   localparam int ST_ZERO_BIT    = 0;
   localparam int ST_RUN_BIT     = 1;
   localparam int ST_PLL_EN_BIT  = 2;
   localparam int ST_SEARCH_BIT  = 3;
   localparam int ST_FM_BIT      = 4;
   localparam int ST_PLL_SRC_BIT = 5;

   // reset values
   localparam logic [7:0] TC_RESET        = 8'h00;
   localparam logic       BGEN_EN_RESET   = 1'b0;
   localparam logic       BGEN_SRC_RESET  = 1'b0;
   localparam logic [1:0] ENC_RESET       = 2'h0;

   // dpll counter landmarks
   localparam logic [4:0] PLL_SEARCH_COUNT = 5'h10;
   localparam logic [4:0] PLL_ADJ_COUNT    = 5'h05;
   localparam logic [4:0] NRZI_LATE_LAST   = 5'h0e;
   localparam logic [4:0] NRZI_EARLY_FIRST = 5'h11;
   localparam logic [4:0] FM_EARLY_FIRST   = 5'h10;
   localparam logic [4:0] FM_EARLY_LAST    = 5'h12;
   localparam logic [4:0] FM_LATE_FIRST    = 5'h0c;
   localparam logic [4:0] FM_LATE_LAST     = 5'h0f;

   typedef enum logic [1:0] {ENC_NRZ, ENC_NRZI, ENC_FM1, ENC_FM0} line_enc_t;

   typedef enum logic [2:0] {
      CMD_NULL, CMD_ENTER_SEARCH, CMD_CLEAR_ADJUST, CMD_DISABLE_PLL,
      CMD_SRC_BGEN, CMD_SRC_PIN, CMD_MODE_FM, CMD_MODE_NRZI
   } pll_cmd_t;

   typedef enum logic [1:0] {ADJ_NONE, ADJ_SHORTEN, ADJ_EXTEND} pll_adj_t;

endpackage

// file: baud_gen_encoding_dpll.sv
// baud generator, line encoder/decoder and digital pll behind a wishbone slave
//
// Operation
// - 17-bit down-counter, two-byte constant, divide-by-two output
// - low byte and high byte form constant
// - rate is clock over 2*mode*(tc+2)
// - source bit picks clock pin or bus clock
// - enable bit runs generator, reset clears it
// - enable synchronised on start, stops at once
// - zero count reloads constant and toggles output
// - zero signal one cycle, held, reset active
// - reset selects the clock pin source
// - two bits choose encoding, always in effect
// - nrz: one high, zero low
// - fm1: boundary transition, mid transition for one
// - fm0: boundary transition, mid transition for zero
// - receiver and transmitter: falling edge in nrz types, both edges in fm
// - pll: 5-bit counter, edge detector, two decoders
// - three command bits drive seven pll commands
// - enter search enables pll or restarts search
// - search holds count until first data edge
// - nrzi: 32x clock, identical mid-cell outputs
// - fm: 16x clock, transmit lags quarter cycle
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module baud_gen_encoding_dpll
   import bgen_dpll_pkg::*;
#(
   parameter int TC_WIDTH = 16
)
(
   input  wire logic        sys_clk,             // system and bus clock
   input  wire logic        reset,               // synchronous, active high
   input  wire logic        wb_cyc_i,            // wishbone cycle
   input  wire logic        wb_stb_i,            // wishbone strobe
   input  wire logic        wb_we_i,             // wishbone write
   input  wire logic [7:0]  wb_adr_i,            // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,            // wishbone byte lanes
   input  wire logic [31:0] wb_dat_i,            // wishbone write data
   output logic      [31:0] wb_dat_o,            // wishbone read data
   output logic             wb_ack_o,            // wishbone acknowledge
   input  wire logic        recv_xmit_clock_pin, // clock pin, asynchronous
   input  wire logic        rx_line_pin,         // encoded receive line, asynchronous
   input  wire logic        tx_data,             // next transmit bit
   output logic             tx_bit_take,         // pulse: tx_data consumed
   output logic             tx_line,             // encoded transmit line
   output logic             rx_bit,              // decoded receive bit
   output logic             rx_bit_valid,        // pulse: rx_bit is new
   output logic             bgen_out,            // generator divide-by-two output
   output logic             bgen_zero_count,     // generator zero count
   output logic             dpll_rx_clk,         // pll receive clock
   output logic             dpll_tx_clk          // pll transmit clock
);

   // register state
   logic [7:0]          tc_low;
   logic [7:0]          tc_high;
   logic                bgen_enable;
   logic                bgen_source;
   logic [1:0]          line_enc;
   logic                tclk_from_pll;
   logic                rclk_from_pll;
   logic                cmd_valid;
   pll_cmd_t            cmd;

   // synchronisers
   logic [1:0]          pin_sync;
   logic [1:0]          rxd_sync;
   logic                pin_prev;
   logic                rxd_prev;
   logic                pin_rise;
   logic                rxd_edge;

   // generator
   logic [TC_WIDTH-1:0] time_const;
   logic [TC_WIDTH:0]   bgen_cnt;
   logic [1:0]          en_sync;
   logic                bgen_tick;
   logic                bgen_run;
   logic                bgen_rise;
   logic                bgen_fall;

   // pll
   logic [4:0]          pll_cnt;
   logic                pll_enable;
   logic                pll_search;
   logic                pll_fm;
   logic                pll_src_bgen;
   logic                pll_tick;
   logic                edge_pending;
   pll_adj_t            pll_adj;

   // encoder and decoder
   logic                tclk_level;
   logic                tclk_prev;
   logic                rclk_level;
   logic                rclk_prev;
   logic                tx_cur_bit;
   logic                rx_first;
   logic                rx_last_level;
   logic                wr_hit;

   assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

   // single-cycle ack, deasserted the cycle after it is given
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   // register writes; unmapped writes are acknowledged and dropped
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tc_low        <= TC_RESET;
         tc_high       <= TC_RESET;
         bgen_enable   <= BGEN_EN_RESET;
         bgen_source   <= BGEN_SRC_RESET;
         line_enc      <= ENC_RESET;
         tclk_from_pll <= 1'b0;
         rclk_from_pll <= 1'b0;
      end
      else if (wr_hit)
      begin
         if (wb_adr_i == ADDR_TC_LOW)
            tc_low <= wb_dat_i[7:0];
         else if (wb_adr_i == ADDR_TC_HIGH)
            tc_high <= wb_dat_i[7:0];
         else if (wb_adr_i == ADDR_BAUD_PLL_CTL)
         begin
            bgen_enable <= wb_dat_i[BPC_ENABLE_BIT];
            bgen_source <= wb_dat_i[BPC_SOURCE_BIT];
         end
         else if (wb_adr_i == ADDR_MISC_LINE)
            line_enc <= wb_dat_i[MLC_ENC_MSB:MLC_ENC_LSB];
         else if (wb_adr_i == ADDR_CLOCK_ROUTE)
         begin
            tclk_from_pll <= wb_dat_i[0];
            rclk_from_pll <= wb_dat_i[1];
         end
      end
   end

   // pll command decode, a pulse on each control register write
   // command in top three bits
   assign cmd_valid = wr_hit && (wb_adr_i == ADDR_BAUD_PLL_CTL);
   assign cmd       = pll_cmd_t'(wb_dat_i[BPC_CMD_MSB:BPC_CMD_LSB]);

   // read mux; write-only registers read as zero
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         wb_dat_o <= 32'h00000000;
      else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
      begin
         wb_dat_o <= 32'h00000000;
         if (wb_adr_i == ADDR_STATUS)
         begin
            wb_dat_o[ST_ZERO_BIT]    <= bgen_zero_count;
            wb_dat_o[ST_RUN_BIT]     <= bgen_run;
            wb_dat_o[ST_PLL_EN_BIT]  <= pll_enable;
            wb_dat_o[ST_SEARCH_BIT]  <= pll_search;
            wb_dat_o[ST_FM_BIT]      <= pll_fm;
            wb_dat_o[ST_PLL_SRC_BIT] <= pll_src_bgen;
         end
         else if (wb_adr_i == ADDR_CLOCK_ROUTE)
            wb_dat_o[1:0] <= {rclk_from_pll, tclk_from_pll};
      end
   end

   // pin synchronisers; only the second stage is looked at
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_sync <= 2'h0;
         rxd_sync <= 2'h0;
         pin_prev <= 1'b0;
         rxd_prev <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[0], recv_xmit_clock_pin};
         rxd_sync <= {rxd_sync[0], rx_line_pin};
         pin_prev <= pin_sync[1];
         rxd_prev <= rxd_sync[1];
      end
   end

   assign pin_rise = pin_sync[1] && !pin_prev;
   assign rxd_edge = rxd_sync[1] ^ rxd_prev;

   // low byte from tc_low, high byte from tc_high
   assign time_const = {tc_high, tc_low};

   // source 0 counts pin rises, 1 counts every bus clock
   assign bgen_tick = bgen_source ? 1'b1 : pin_rise;

   // enable passes two generator ticks; clearing is immediate
   always_ff @(posedge sys_clk)
   begin
      if (reset || !bgen_enable)
         en_sync <= 2'h0;
      else if (bgen_tick)
         en_sync <= {en_sync[0], 1'b1};
   end

   assign bgen_run = bgen_enable && en_sync[1];

   // reload tc+1 so each half period is tc+2 ticks
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         bgen_cnt <= '0;
         bgen_out <= 1'b0;
      end
      else if (bgen_run && bgen_tick)
      begin
         if (bgen_cnt == '0)
         begin
            bgen_cnt <= {1'b0, time_const} + {{TC_WIDTH{1'b0}}, 1'b1};
            bgen_out <= !bgen_out;
         end
         else
            bgen_cnt <= bgen_cnt - {{TC_WIDTH{1'b0}}, 1'b1};
      end
   end

   // zero while count is 0; held when stopped; active from reset
   assign bgen_zero_count = (bgen_cnt == '0);

   // output edges of the generator, seen as one-cycle pulses
   assign bgen_rise = bgen_run && bgen_tick && bgen_zero_count && !bgen_out;
   assign bgen_fall = bgen_run && bgen_tick && bgen_zero_count && bgen_out;

   // pll clock from a two-way choice of sources
   assign pll_tick = pll_src_bgen ? bgen_rise : pin_rise;

   // pll control state from commands
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pll_enable   <= 1'b0;
         pll_src_bgen <= 1'b0;
         pll_fm       <= 1'b0;
      end
      else if (cmd_valid)
      begin
         case (cmd)
            CMD_ENTER_SEARCH: pll_enable   <= 1'b1;
            CMD_DISABLE_PLL:  pll_enable   <= 1'b0;
            CMD_SRC_BGEN:     pll_src_bgen <= 1'b1;
            CMD_SRC_PIN:      pll_src_bgen <= 1'b0;
            CMD_MODE_FM:      pll_fm       <= 1'b1;
            CMD_MODE_NRZI:    pll_fm       <= 1'b0;
            default:          pll_enable   <= pll_enable;
         endcase
      end
   end

   // edge detector, remembered until the next pll tick
   always_ff @(posedge sys_clk)
   begin
      if (reset || !pll_enable)
         edge_pending <= 1'b0;
      else if (pll_tick)
         edge_pending <= 1'b0;
      else if (rxd_edge)
         edge_pending <= 1'b1;
   end

   // 5-bit counter, held at search count while idle
   always_ff @(posedge sys_clk)
   begin
      if (reset || !pll_enable)
      begin
         pll_cnt    <= PLL_SEARCH_COUNT;
         pll_search <= 1'b1;
         pll_adj    <= ADJ_NONE;
      end
      else if (cmd_valid && cmd == CMD_ENTER_SEARCH)
      begin
         pll_cnt    <= PLL_SEARCH_COUNT;
         pll_search <= 1'b1;
         pll_adj    <= ADJ_NONE;
      end
      else if (cmd_valid && cmd == CMD_CLEAR_ADJUST)
         pll_adj <= ADJ_NONE;
      else if (pll_tick)
      begin
         if (pll_search)
         begin
            // first edge taken as a cell boundary
            if (edge_pending || rxd_edge)
            begin
               pll_search <= 1'b0;
               pll_cnt    <= PLL_SEARCH_COUNT + 5'h01;
            end
         end
         else
         begin
            // correction by deleting or doubling the adjust count
            if (pll_adj == ADJ_SHORTEN && pll_cnt == PLL_ADJ_COUNT - 5'h01)
               pll_cnt <= PLL_ADJ_COUNT + 5'h01;
            else if (!(pll_adj == ADJ_EXTEND && pll_cnt == PLL_ADJ_COUNT))
               pll_cnt <= pll_cnt + 5'h01;
            if ((pll_adj == ADJ_SHORTEN && pll_cnt == PLL_ADJ_COUNT - 5'h01)
                || (pll_adj == ADJ_EXTEND && pll_cnt == PLL_ADJ_COUNT))
               pll_adj <= ADJ_NONE;
            else if ((edge_pending || rxd_edge) && !pll_fm)
            begin
               if (pll_cnt <= NRZI_LATE_LAST)
                  pll_adj <= ADJ_SHORTEN;
               else if (pll_cnt >= NRZI_EARLY_FIRST)
                  pll_adj <= ADJ_EXTEND;
            end
            else if ((edge_pending || rxd_edge) && pll_fm)
            begin
               // data transitions outside the windows are ignored
               if (pll_cnt >= FM_EARLY_FIRST && pll_cnt <= FM_EARLY_LAST)
                  pll_adj <= ADJ_EXTEND;
               else if (pll_cnt >= FM_LATE_FIRST && pll_cnt <= FM_LATE_LAST)
                  pll_adj <= ADJ_SHORTEN;
            end
         end
      end
   end

   // two output decoders, registered
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         dpll_rx_clk <= 1'b1;
         dpll_tx_clk <= 1'b1;
      end
      else if (pll_fm)
      begin
         // rx edges at 1/4 and 3/4 cell, tx a quarter later
         dpll_rx_clk <= pll_cnt[3] ^ pll_cnt[2];
         dpll_tx_clk <= pll_cnt[3];
      end
      else
      begin
         dpll_rx_clk <= pll_cnt[4];
         dpll_tx_clk <= pll_cnt[4];
      end
   end

   // transmit and receive clock routing
   assign tclk_level = tclk_from_pll ? dpll_tx_clk : bgen_out;
   assign rclk_level = rclk_from_pll ? dpll_rx_clk : bgen_out;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tclk_prev <= 1'b0;
         rclk_prev <= 1'b0;
      end
      else
      begin
         tclk_prev <= tclk_level;
         rclk_prev <= rclk_level;
      end
   end

   // encoder: falling edge is the cell boundary, rising mid-cell
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tx_line     <= 1'b1;
         tx_cur_bit  <= 1'b1;
         tx_bit_take <= 1'b0;
      end
      else
      begin
         tx_bit_take <= 1'b0;
         if (tclk_prev && !tclk_level)
         begin
            tx_bit_take <= 1'b1;
            tx_cur_bit  <= tx_data;
            case (line_enc_t'(line_enc))
               ENC_NRZ:  tx_line <= tx_data;
               ENC_NRZI: tx_line <= tx_line ^ !tx_data;
               default:  tx_line <= !tx_line;
            endcase
         end
         else if (!tclk_prev && tclk_level)
         begin
            if (line_enc_t'(line_enc) == ENC_FM1 && tx_cur_bit)
               tx_line <= !tx_line;
            else if (line_enc_t'(line_enc) == ENC_FM0 && !tx_cur_bit)
               tx_line <= !tx_line;
         end
      end
   end

   // decoder: nrz types on falling edge, fm on both
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rx_bit        <= 1'b0;
         rx_bit_valid  <= 1'b0;
         rx_first      <= 1'b0;
         rx_last_level <= 1'b1;
      end
      else
      begin
         rx_bit_valid <= 1'b0;
         if (!rclk_prev && rclk_level)
            rx_first <= rxd_sync[1];
         else if (rclk_prev && !rclk_level)
         begin
            rx_bit_valid  <= 1'b1;
            rx_last_level <= rxd_sync[1];
            case (line_enc_t'(line_enc))
               ENC_NRZ:  rx_bit <= rxd_sync[1];
               ENC_NRZI: rx_bit <= (rxd_sync[1] == rx_last_level);
               ENC_FM1:  rx_bit <= (rxd_sync[1] != rx_first);
               default:  rx_bit <= (rxd_sync[1] == rx_first);
            endcase
         end
      end
   end

endmodule

// file: bgen_dpll_asserts.sv
// assertion checker for the baud generator, encoder and pll block
`timescale 1ns/1ps
module bgen_dpll_asserts
   import bgen_dpll_pkg::*;
(
   input wire logic        sys_clk,         // clock
   input wire logic        reset,           // sync reset
   input wire logic        wb_cyc_i,        // bus cycle
   input wire logic        wb_stb_i,        // bus strobe
   input wire logic        wb_we_i,         // bus write
   input wire logic [7:0]  wb_adr_i,        // bus address
   input wire logic [3:0]  wb_sel_i,        // byte lanes
   input wire logic [31:0] wb_dat_i,        // write data
   input wire logic        wb_ack_o,        // acknowledge
   input wire logic        tx_bit_take,     // bit consumed
   input wire logic        tx_line,         // encoded line
   input wire logic        rx_bit_valid,    // bit strobe
   input wire logic        bgen_out,        // generator output
   input wire logic        bgen_zero_count, // zero count
   input wire logic        dpll_rx_clk,     // pll receive clock
   input wire logic        dpll_tx_clk      // pll transmit clock
);
   logic gen_en;  // shadow of generator enable
   logic mode_fm; // shadow of pll fm mode
   logic ctl_wr;  // control write landing

   // a write takes effect only at the acknowledging edge
   assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                   && wb_adr_i == ADDR_BAUD_PLL_CTL;

   // shadow registers, so the checks know enable and mode without peeking inside
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         gen_en <= BGEN_EN_RESET;
      else if (ctl_wr)
         gen_en <= wb_dat_i[BPC_ENABLE_BIT];
   end
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         mode_fm <= 1'b0;
      else if (ctl_wr && wb_dat_i[BPC_CMD_MSB:BPC_CMD_LSB] == CMD_MODE_FM)
         mode_fm <= 1'b1;
      else if (ctl_wr && wb_dat_i[BPC_CMD_MSB:BPC_CMD_LSB] == CMD_MODE_NRZI)
         mode_fm <= 1'b0;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // generator output quiet for two clock cycles from the rise of the enable
   sequence s_quiet2;
      $stable(bgen_out) ##1 $stable(bgen_out);
   endsequence
   // request waiting for the slave
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   a_reset_state: assert property (
      $past(reset) |-> !wb_ack_o && bgen_zero_count && !bgen_out && tx_line
      && dpll_rx_clk && dpll_tx_clk) else $error("state after reset wrong");
   a_ack_answers: assert property (
      s_req |=> wb_ack_o) else $error("request not acknowledged in one cycle");
   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("acknowledge longer than one cycle");
   a_start_sync: assert property (
      $rose(gen_en) |-> s_quiet2) else $error("generator started without sync delay");
   a_stop_at_once: assert property (
      !gen_en && !$past(gen_en) && !$past(reset)
      |-> $stable(bgen_out) && $stable(bgen_zero_count)) else $error("generator moved while off");
   a_toggle_zero: assert property (
      $changed(bgen_out) && !$past(reset) |-> $past(bgen_zero_count))
      else $error("output toggled away from zero count");
   a_nrzi_equal: assert property (
      !mode_fm && !$past(mode_fm) && !$past(mode_fm, 2) |-> dpll_rx_clk == dpll_tx_clk)
      else $error("pll clocks differ in nrzi");
   a_take_pulse: assert property (
      tx_bit_take |=> !tx_bit_take) else $error("take pulse too long");
   a_valid_pulse: assert property (
      rx_bit_valid |=> !rx_bit_valid) else $error("receive strobe too long");
endmodule

bind baud_gen_encoding_dpll bgen_dpll_asserts u_chk (
   .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .tx_bit_take(tx_bit_take), .tx_line(tx_line),
   .rx_bit_valid(rx_bit_valid), .bgen_out(bgen_out), .bgen_zero_count(bgen_zero_count),
   .dpll_rx_clk(dpll_rx_clk), .dpll_tx_clk(dpll_tx_clk)
);

// file: remote_station.sv
// model of the remote station on the receive line and clock pin
`timescale 1ns/1ps
module remote_station (
   input  wire logic sys_clk, // timing reference
   output logic      rx_out,  // encoded data toward the block
   output logic      pin_clk  // clock pin toward the block
);
   // idle mark level; the pin clock stands still outside bursts
   initial
   begin
      rx_out = 1'b1;
      pin_clk = 1'b0;
   end

   // burst of n pin periods, each two half spans of bench clocks
   task automatic clock_burst(input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge sys_clk);
         pin_clk <= 1'b1;
         repeat (half) @(posedge sys_clk);
         pin_clk <= 1'b0;
      end
   endtask

   task automatic line_edge();
      @(posedge sys_clk);
      rx_out <= ~rx_out;
   endtask
endmodule

// file: tb.sv
// self-checking bench for the baud generator, encoder and pll block
`timescale 1ns/1ps
module tb
   import bgen_dpll_pkg::*;
;
   logic        sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pin, rx_line;
   logic        tx_data, tx_bit_take, tx_line, rx_bit, rx_bit_valid;
   logic        bgen_out, bgen_zero_count, dpll_rx_clk, dpll_tx_clk;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   int          n_fail, n_tests;

   baud_gen_encoding_dpll uut (
      .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .recv_xmit_clock_pin(pin),
      .rx_line_pin(rx_line), .tx_data(tx_data), .tx_bit_take(tx_bit_take),
      .tx_line(tx_line), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .bgen_out(bgen_out),
      .bgen_zero_count(bgen_zero_count), .dpll_rx_clk(dpll_rx_clk), .dpll_tx_clk(dpll_tx_clk)
   );
   remote_station u_remote (.sys_clk(sys_clk), .rx_out(rx_line), .pin_clk(pin));

   // 100 MHz bench clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic cycle; an endless wait is cut by the watchdog only
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // cycles between two toggles of the generator output, bounded
   task automatic measure_gap(output int g);
      logic last;
      @(posedge sys_clk);
      last = bgen_out;
      for (g = 0; bgen_out === last && g < 2000; g++) @(posedge sys_clk);
      last = bgen_out;
      for (g = 0; bgen_out === last && g < 2000; g++) @(posedge sys_clk);
   endtask

   function automatic logic [7:0] st(logic en, logic srch, logic fm, logic src);
      logic [7:0] s;
      s = 8'h00;
      s[ST_RUN_BIT] = 1'b1;
      s[ST_PLL_EN_BIT] = en;
      s[ST_SEARCH_BIT] = srch;
      s[ST_FM_BIT] = fm;
      s[ST_PLL_SRC_BIT] = src;
      return s;
   endfunction

   // expected {first half, second half} of a cell from bit and previous level
   function automatic logic [1:0] enc_cell(line_enc_t e, logic b, logic p);
      case (e)
         ENC_NRZ:  return {b, b};
         ENC_NRZI: return b ? {p, p} : {~p, ~p};
         ENC_FM1:  return b ? {~p, p} : {~p, ~p};
         default:  return b ? {~p, ~p} : {~p, p};
      endcase
   endfunction

   task automatic t_reset();
      logic [31:0] q;
      check_val("zero count", 1, bgen_zero_count);
      check_val("gen output", 0, bgen_out);
      check_val("pll clocks", 3, {dpll_rx_clk, dpll_tx_clk});
      bus(1'b0, ADDR_STATUS, 8'h00, q);
      check_val("status", 32'h1, q & 32'h37);
      wr(8'hf0, 8'hff);
      bus(1'b0, 8'hf0, 8'h00, q);
      check_val("unmapped", 0, q);
   endtask

   // no source write: reset already picks the clock pin
   task automatic t_pin();
      int g;
      logic held;
      wr(ADDR_TC_LOW, 8'h00);
      wr(ADDR_TC_HIGH, 8'h00);
      wr(ADDR_BAUD_PLL_CTL, 8'h01);
      fork
         measure_gap(g);
         u_remote.clock_burst(20, 10);
      join
      check_val("pin gap", (0 + 2) * 20, g);
      held = bgen_out;
      repeat (60) @(posedge sys_clk);
      check_val("pin idle", held, bgen_out);
      wr(ADDR_BAUD_PLL_CTL, 8'h00);
   endtask

   task automatic t_rate();
      logic [15:0] tcs [3] = '{16'h0000, 16'h0007, 16'h0102};
      int g;
      logic held;
      foreach (tcs[i])
      begin
         wr(ADDR_TC_LOW, tcs[i][7:0]);
         wr(ADDR_TC_HIGH, tcs[i][15:8]);
         wr(ADDR_BAUD_PLL_CTL, 8'h02);
         wr(ADDR_BAUD_PLL_CTL, 8'h03);
         measure_gap(g);
         check_val("bus gap", tcs[i] + 2, g);
         wr(ADDR_BAUD_PLL_CTL, 8'h02);
         @(posedge sys_clk);
         held = bgen_out;
         repeat (40) @(posedge sys_clk);
         check_val("stopped", held, bgen_out);
      end
   endtask

   // every line code, cells of eight clocks, first cell only seeds the level
   task automatic t_encode();
      logic [9:0] pat = 10'b1011001001;
      logic [1:0] lv;
      logic p, b;
      int k;
      wr(ADDR_TC_LOW, 8'h02);
      wr(ADDR_TC_HIGH, 8'h00);
      wr(ADDR_CLOCK_ROUTE, 8'h00);
      for (int e = 0; e < 4; e++)
      begin
         wr(ADDR_BAUD_PLL_CTL, 8'h02);
         wr(ADDR_MISC_LINE, 8'(e << MLC_ENC_LSB));
         tx_data <= pat[0];
         wr(ADDR_BAUD_PLL_CTL, 8'h03);
         for (int i = 0; i < 10; i++)
         begin
            @(posedge sys_clk);
            for (k = 0; tx_bit_take !== 1'b1 && k < 100; k++) @(posedge sys_clk);
            b = tx_data;
            tx_data <= pat[(i + 1) % 10];
            repeat (2) @(posedge sys_clk);
            lv[1] = tx_line;
            repeat (4) @(posedge sys_clk);
            lv[0] = tx_line;
            if (i > 0)
               check_val("cell", enc_cell(line_enc_t'(e), b, p), lv);
            p = lv[0];
         end
         check_val("rx idle", e != ENC_FM1, rx_bit);
      end
   endtask

   task automatic pll_step(input pll_cmd_t c, input logic [7:0] exp, input logic [7:0] m);
      logic [31:0] q;
      wr(ADDR_BAUD_PLL_CTL, {c, 5'h03});
      bus(1'b0, ADDR_STATUS, 8'h00, q);
      check_val("pll status", exp & m, q[7:0] & m);
   endtask

   // sources only change while the pll is off
   task automatic t_pll();
      wr(ADDR_TC_LOW, 8'h00);
      pll_step(CMD_SRC_BGEN, st(0, 0, 0, 1), 8'h26);
      pll_step(CMD_ENTER_SEARCH, st(1, 1, 0, 1), 8'h3e);
      repeat (100) @(posedge sys_clk);
      check_val("search hold", 3, {dpll_rx_clk, dpll_tx_clk});
      u_remote.line_edge();
      repeat (100) @(posedge sys_clk);
      check_val("tracking", 0, {dpll_rx_clk, dpll_tx_clk});
      pll_step(CMD_NULL, st(1, 0, 0, 1), 8'h3e);
      pll_step(CMD_ENTER_SEARCH, st(1, 1, 0, 1), 8'h3e);
      pll_step(CMD_DISABLE_PLL, st(0, 0, 0, 1), 8'h36);
      pll_step(CMD_MODE_FM, st(0, 0, 1, 1), 8'h36);
      check_val("fm decode", 0, {dpll_rx_clk, dpll_tx_clk});
      pll_step(CMD_MODE_NRZI, st(0, 0, 0, 1), 8'h36);
      check_val("nrzi decode", 3, {dpll_rx_clk, dpll_tx_clk});
      pll_step(CMD_CLEAR_ADJUST, st(0, 0, 0, 1), 8'h36);
      pll_step(CMD_SRC_PIN, st(0, 0, 0, 0), 8'h36);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog well beyond the run's length
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end

   initial
   begin
      n_fail = 0;
      n_tests = 0;
      reset = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      tx_data = 1'b0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_pin();
      t_rate();
      t_encode();
      t_pll();
      conclude();
   end
endmodule
